// [core/timing_pin_pkg.sv]
// constants, types and field layout for the timing pin multiplexer
package timing_pin_pkg;

    localparam int unsigned PIN_COUNT  = 6;
    localparam int unsigned ADDR_BITS  = 8;

    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] PIN_OE_OFFSET = 8'h04;
    localparam logic [7:0] STROBE_OFFSET = 8'h08;
    localparam logic [7:0] STATUS_OFFSET = 8'h0c;

    // control and strobe fields
    localparam int unsigned CTRL_SCAN_EN_BIT   = 0;
    localparam int unsigned CTRL_ANALOG_SEL_BIT = 1;
    localparam int unsigned CTRL_PRETRIG_BIT   = 2;
    localparam int unsigned STROBE_LEVEL_BIT   = 0;

    // status fields
    localparam int unsigned STATUS_PIN_LSB   = 0;
    localparam int unsigned STATUS_DIR0_BIT  = 6;
    localparam int unsigned STATUS_DIR1_BIT  = 7;
    localparam int unsigned STATUS_STATE_LSB = 8;

    // general io lines that steer counter direction
    localparam int unsigned COUNTER0_DIR_LINE = 6;
    localparam int unsigned COUNTER1_DIR_LINE = 7;

    // reset values
    localparam logic [2:0]           CTRL_RESET   = 3'h0;
    localparam logic [PIN_COUNT-1:0] PIN_OE_RESET = 6'h00;
    localparam logic                 STROBE_RESET = 1'b1;

    // pulse widths
    localparam int unsigned CLOCK_PERIOD_NS = 10;
    localparam int unsigned PULSE_WIDTH_NS  = 50;
    localparam int unsigned PULSE_CYCLES    =
        (PULSE_WIDTH_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // pulse channel indices
    localparam int unsigned PULSE_COUNT    = 5;
    localparam int unsigned PULSE_START    = 0;
    localparam int unsigned PULSE_REF      = 1;
    localparam int unsigned PULSE_CONVERT  = 2;
    localparam int unsigned PULSE_UPDATE   = 3;
    localparam int unsigned PULSE_SCAN     = 4;

    // acquisition phase, one-hot
    typedef enum logic [2:0] {
        ACQ_IDLE = 3'b001,
        ACQ_PRE  = 3'b010,
        ACQ_POST = 3'b100
    } acq_state_t;

    // internal timing events from the acquisition and counter logic
    typedef struct packed {
        logic acq_start;
        logic ref_start;
        logic acq_done;
        logic conv_start;
        logic sample_done;
        logic update;
        logic ctr1_source;
        logic ctr1_gate;
        logic ctr1_out;
    } timing_events_t;

    // timing signals presented to the connector
    typedef struct packed {
        logic acquisition_start_trigger;
        logic reference_trigger;
        logic conversion_strobe_n;
        logic counter1_source_echo;
        logic counter1_gate_echo;
        logic update_strobe_n;
    } pin_drive_t;

endpackage

// [core/pulse_gen.sv]
// fixed-width active-high pulse started by a one-cycle fire
`timescale 1ns/1ps
module pulse_gen #(
    parameter int unsigned CYCLES = 1
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic fire,
    output logic      pulse_ff
);
    logic [7:0] count_ff;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_ff <= 8'h00;
            pulse_ff <= 1'b0;
        end else if (fire) begin
            count_ff <= 8'(CYCLES - 1);
            pulse_ff <= 1'b1;
        end else if (count_ff != 8'h00) begin
            count_ff <= count_ff - 8'h01;
        end else begin
            pulse_ff <= 1'b0;
        end
    end
endmodule

// [core/timing_pin_io_mux.sv]
// connector timing pin multiplexer with ahb-lite register slave
//
// The implementer's own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module timing_pin_io_mux (
    input  wire logic                                   clock,
    input  wire logic                                   rst,
    // ahb-lite slave
    input  wire logic                                   hsel,
    input  wire logic [31:0]                            haddr,
    input  wire logic [1:0]                             htrans,
    input  wire logic                                   hwrite,
    input  wire logic [2:0]                             hsize,
    input  wire logic [31:0]                            hwdata,
    input  wire logic                                   hready,
    output logic [31:0]                                 hrdata,
    output logic                                        hreadyout,
    output logic                                        hresp,
    // internal timing sources
    input  wire timing_pin_pkg::timing_events_t         events,
    // function pins
    input  wire logic [timing_pin_pkg::PIN_COUNT-1:0]   pin_in,
    output logic [timing_pin_pkg::PIN_COUNT-1:0]        pin_out,
    output logic [timing_pin_pkg::PIN_COUNT-1:0]        pin_oe,
    // dedicated outputs
    output logic                                        per_conversion_pulse,
    output logic                                        software_strobe_n,
    output logic                                        counter1_output,
    // routing side
    output logic [timing_pin_pkg::PIN_COUNT-1:0]        routing_level,
    output logic                                        analog_trigger_sel,
    // general io taps
    input  wire logic [7:0]                             general_io_lines,
    output logic                                        counter0_up_down,
    output logic                                        counter1_up_down
);
    localparam int unsigned NP = timing_pin_pkg::PIN_COUNT;

    // bus state
    logic                  pend_ff;
    logic                  pend_write_ff;
    logic [7:0]            pend_addr_ff;
    logic [31:0]           hrdata_ff;
    logic                  hreadyout_ff;

    // software registers
    logic [2:0]            ctrl_ff;
    logic [NP-1:0]         pin_oe_ff;
    logic                  strobe_ff;

    // block state
    timing_pin_pkg::acq_state_t acq_ff;
    timing_pin_pkg::acq_state_t nxt_acq;
    logic [NP-1:0]         pin_out_ff;
    logic [NP-1:0]         routing_ff;
    logic                  analog_sel_ff;
    logic                  ctr1_out_ff;
    logic                  dir0_ff;
    logic                  dir1_ff;

    // pulse channels
    logic [timing_pin_pkg::PULSE_COUNT-1:0] fire;
    logic [timing_pin_pkg::PULSE_COUNT-1:0] pulse;
    timing_pin_pkg::pin_drive_t drive;

    logic                  addr_take;
    logic [31:0]           read_word;
    logic                  scan_en;
    logic                  analog_sel;
    logic                  pretrig;

    assign scan_en    = ctrl_ff[timing_pin_pkg::CTRL_SCAN_EN_BIT];
    assign analog_sel = ctrl_ff[timing_pin_pkg::CTRL_ANALOG_SEL_BIT];
    assign pretrig    = ctrl_ff[timing_pin_pkg::CTRL_PRETRIG_BIT];

    // address phase accepted
    assign addr_take = hsel && htrans[1] && hready;

    // read mux, used in the wait cycle of the data phase
    always_comb begin
        read_word = 32'h0000_0000;
        case (pend_addr_ff)
            timing_pin_pkg::CTRL_OFFSET: begin
                read_word[2:0] = ctrl_ff;
            end
            timing_pin_pkg::PIN_OE_OFFSET: begin
                read_word[NP-1:0] = pin_oe_ff;
            end
            timing_pin_pkg::STROBE_OFFSET: begin
                read_word[timing_pin_pkg::STROBE_LEVEL_BIT] = strobe_ff;
            end
            timing_pin_pkg::STATUS_OFFSET: begin
                read_word[timing_pin_pkg::STATUS_PIN_LSB +: NP] = routing_ff;
                read_word[timing_pin_pkg::STATUS_DIR0_BIT] = dir0_ff;
                read_word[timing_pin_pkg::STATUS_DIR1_BIT] = dir1_ff;
                read_word[timing_pin_pkg::STATUS_STATE_LSB +: 3] = acq_ff;
            end
            default: begin
                read_word = 32'h0000_0000;
            end
        endcase
    end

    // ahb-lite handshake: one wait state in every data phase
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pend_ff       <= 1'b0;
            pend_write_ff <= 1'b0;
            pend_addr_ff  <= 8'h00;
            hreadyout_ff  <= 1'b1;
        end else if (pend_ff) begin
            pend_ff       <= 1'b0;
            hreadyout_ff  <= 1'b1;
        end else if (addr_take) begin
            pend_ff       <= 1'b1;
            pend_write_ff <= hwrite;
            pend_addr_ff  <= haddr[7:0];
            hreadyout_ff  <= 1'b0;
        end
    end

    // read data loaded in the wait cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (pend_ff && !pend_write_ff) begin
            hrdata_ff <= read_word;
        end
    end

    // control register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_ff <= timing_pin_pkg::CTRL_RESET;
        end else if (pend_ff && pend_write_ff &&
                     pend_addr_ff == timing_pin_pkg::CTRL_OFFSET) begin
            ctrl_ff <= hwdata[2:0];
        end
    end

    // pin driver enables, all off after reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_oe_ff <= timing_pin_pkg::PIN_OE_RESET;
        end else if (pend_ff && pend_write_ff &&
                     pend_addr_ff == timing_pin_pkg::PIN_OE_OFFSET) begin
            pin_oe_ff <= hwdata[NP-1:0];
        end
    end

    // software strobe level, changed by writes only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            strobe_ff <= timing_pin_pkg::STROBE_RESET;
        end else if (pend_ff && pend_write_ff &&
                     pend_addr_ff == timing_pin_pkg::STROBE_OFFSET) begin
            strobe_ff <= hwdata[timing_pin_pkg::STROBE_LEVEL_BIT];
        end
    end

    // acquisition phase tracking
    always_comb begin
        nxt_acq = acq_ff;
        case (acq_ff)
            timing_pin_pkg::ACQ_IDLE: begin
                if (events.acq_start) begin
                    nxt_acq = pretrig ? timing_pin_pkg::ACQ_PRE
                                      : timing_pin_pkg::ACQ_POST;
                end
            end
            timing_pin_pkg::ACQ_PRE: begin
                if (events.acq_done) begin
                    nxt_acq = timing_pin_pkg::ACQ_IDLE;
                end else if (events.ref_start) begin
                    nxt_acq = timing_pin_pkg::ACQ_POST;
                end
            end
            timing_pin_pkg::ACQ_POST: begin
                if (events.acq_done) begin
                    nxt_acq = timing_pin_pkg::ACQ_IDLE;
                end
            end
            default: begin
                nxt_acq = timing_pin_pkg::ACQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            acq_ff <= timing_pin_pkg::ACQ_IDLE;
        end else begin
            acq_ff <= nxt_acq;
        end
    end

    // pulse triggers
    always_comb begin
        fire = '0;
        // start of sequence, or of pretrigger conversions
        fire[timing_pin_pkg::PULSE_START] =
            events.acq_start && acq_ff == timing_pin_pkg::ACQ_IDLE;
        // only a pretrigger sequence gives the reference trigger meaning
        fire[timing_pin_pkg::PULSE_REF] =
            events.ref_start && acq_ff == timing_pin_pkg::ACQ_PRE;
        fire[timing_pin_pkg::PULSE_CONVERT] = events.conv_start;
        fire[timing_pin_pkg::PULSE_UPDATE]  = events.update;
        // rises when the sampled input is released
        fire[timing_pin_pkg::PULSE_SCAN] =
            events.sample_done && scan_en;
    end

    genvar g;
    generate
        for (g = 0; g < timing_pin_pkg::PULSE_COUNT; g++) begin : g_pulse
            pulse_gen #(
                .CYCLES (timing_pin_pkg::PULSE_CYCLES)
            ) u_pulse (
                .clock    (clock),
                .rst      (rst),
                .fire     (fire[g]),
                .pulse_ff (pulse[g])
            );
        end
    endgenerate

    // assigned timing signal for each function pin
    always_comb begin
        drive.acquisition_start_trigger = pulse[timing_pin_pkg::PULSE_START];
        drive.reference_trigger         = pulse[timing_pin_pkg::PULSE_REF];
        drive.conversion_strobe_n       = !pulse[timing_pin_pkg::PULSE_CONVERT];
        drive.counter1_source_echo      = events.ctr1_source;
        drive.counter1_gate_echo        = events.ctr1_gate;
        drive.update_strobe_n           = !pulse[timing_pin_pkg::PULSE_UPDATE];
    end

    // pin 0 is bit 5 of the struct, pin 5 is bit 0
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_out_ff <= 6'h3f;
        end else begin
            pin_out_ff <= {<<{drive}};
        end
    end

    // function pin levels broadcast to every routing selector, pin 0 forced low while analog_sel is set
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            routing_ff    <= '0;
            analog_sel_ff <= 1'b0;
        end else begin
            routing_ff    <= pin_in;
            routing_ff[0] <= pin_in[0] && !analog_sel;
            analog_sel_ff <= analog_sel;
        end
    end

    // counter output and direction taps
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctr1_out_ff <= 1'b0;
            dir0_ff     <= 1'b0;
            dir1_ff     <= 1'b0;
        end else begin
            ctr1_out_ff <= events.ctr1_out;
            // sampled only, nothing driven back onto the lines
            dir0_ff <=
                general_io_lines[timing_pin_pkg::COUNTER0_DIR_LINE];
            dir1_ff <=
                general_io_lines[timing_pin_pkg::COUNTER1_DIR_LINE];
        end
    end

    assign hrdata               = hrdata_ff;
    assign hreadyout            = hreadyout_ff;
    assign hresp                = 1'b0;
    assign pin_out              = pin_out_ff;
    assign pin_oe               = pin_oe_ff;
    assign per_conversion_pulse = pulse[timing_pin_pkg::PULSE_SCAN];
    assign software_strobe_n    = strobe_ff;
    assign counter1_output      = ctr1_out_ff;
    assign routing_level        = routing_ff;
    assign analog_trigger_sel   = analog_sel_ff;
    assign counter0_up_down     = dir0_ff;
    assign counter1_up_down     = dir1_ff;
endmodule

// [verif/timing_pin_io_mux_checker.sv]
// port-level assertions for the timing pin multiplexer
`timescale 1ns/1ps
module timing_pin_io_mux_checker (
    input wire logic                           clock,
    input wire logic                           rst,
    input wire logic                           hsel,
    input wire logic [1:0]                     htrans,
    input wire logic                           hready,
    input wire logic                           hreadyout,
    input wire timing_pin_pkg::timing_events_t events,
    input wire logic [5:0]                     pin_in,
    input wire logic [5:0]                     pin_out,
    input wire logic [5:0]                     pin_oe,
    input wire logic                           per_conversion_pulse,
    input wire logic                           software_strobe_n,
    input wire logic                           counter1_output,
    input wire logic [5:0]                     routing_level,
    input wire logic                           analog_trigger_sel,
    input wire logic [7:0]                     general_io_lines,
    input wire logic                           counter0_up_down,
    input wire logic                           counter1_up_down
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    property p_scan_cause;
        $rose(per_conversion_pulse) |-> $past(events.sample_done);
    endproperty
    a_scan_cause: assert property (p_scan_cause)
        else $error("scan pulse rose without a finished sample");

    property p_conv_fall;
        events.conv_start |-> ##[1:3] !pin_out[2];
    endproperty
    a_conv_fall: assert property (p_conv_fall)
        else $error("conversion strobe did not fall");

    property p_update_fall;
        events.update |-> ##[1:3] !pin_out[5];
    endproperty
    a_update_fall: assert property (p_update_fall)
        else $error("update strobe did not fall");

    property p_strobe_write;
        $changed(software_strobe_n) |-> !$past(hreadyout);
    endproperty
    a_strobe_write: assert property (p_strobe_write)
        else $error("software strobe moved outside a bus write");

    property p_ctr1_echo;
        $stable({events.ctr1_gate, events.ctr1_source})[*3]
            |-> pin_out[4:3] == {events.ctr1_gate, events.ctr1_source};
    endproperty
    a_ctr1_echo: assert property (p_ctr1_echo)
        else $error("counter source or gate echo wrong");

    property p_ctr1_out;
        $stable(events.ctr1_out)[*3] |-> counter1_output == events.ctr1_out;
    endproperty
    a_ctr1_out: assert property (p_ctr1_out)
        else $error("counter output pin wrong");

    property p_dir_taps;
        $stable(general_io_lines)[*3]
            |-> {counter1_up_down, counter0_up_down}
                == general_io_lines[7:6];
    endproperty
    a_dir_taps: assert property (p_dir_taps)
        else $error("direction taps wrong");

    property p_routing;
        $stable(pin_in)[*3] ##0 !analog_trigger_sel
            |-> routing_level == pin_in;
    endproperty
    a_routing: assert property (p_routing)
        else $error("routing level does not follow pins");

    property p_analog_mask;
        analog_trigger_sel |-> !routing_level[0];
    endproperty
    a_analog_mask: assert property (p_analog_mask)
        else $error("pin 0 routed while analog trigger selected");

    property p_oe_reset;
        $fell(rst) |-> pin_oe == 6'h00;
    endproperty
    a_oe_reset: assert property (p_oe_reset)
        else $error("pin driver enabled after reset");

    property p_bus_wait;
        hsel && htrans[1] && hready && hreadyout
            |=> !hreadyout ##1 hreadyout;
    endproperty
    a_bus_wait: assert property (p_bus_wait)
        else $error("bus wait state wrong");
endmodule

bind timing_pin_io_mux timing_pin_io_mux_checker
    u_timing_pin_io_mux_checker (.*);

// [verif/ext_circuit.sv]
// connector-side circuitry: resolves function pins, counts scan pulses
`timescale 1ns/1ps
module ext_circuit (
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe,
    input  wire logic [5:0] ext_drive,
    input  wire logic       per_conversion_pulse,
    output logic [5:0]      pin_level,
    output int              scan_count,
    output logic            input_sel
);
    // device driver wins where enabled, else external source
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_drive);
    initial scan_count = 0;
    initial input_sel = 1'b0;
    // input switched only after the scan pulse rises
    always @(posedge per_conversion_pulse) begin
        scan_count++;
        input_sel <= ~input_sel;
    end
endmodule

// [verif/tb_top.sv]
// self-checking bench for the timing pin multiplexer
`timescale 1ns/1ps
module tb_top;
    localparam int EV_START = 8, EV_REF = 7, EV_DONE = 6;
    localparam int EV_CONV = 5, EV_SAMP = 4, EV_UPD = 3;
    logic        clock, rst, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [5:0]  ext, pin_level, pin_out, pin_oe, routing_level;
    logic [7:0]  gio;
    logic        per_conversion_pulse, software_strobe_n, input_sel;
    logic        counter1_output, analog_trigger_sel;
    logic        counter0_up_down, counter1_up_down;
    int          scan_count, fails, checked;
    timing_pin_pkg::timing_events_t ev;

    timing_pin_io_mux u_timing_pin_io_mux (
        .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .events(ev),
        .pin_in(pin_level), .pin_out(pin_out), .pin_oe(pin_oe),
        .per_conversion_pulse(per_conversion_pulse),
        .software_strobe_n(software_strobe_n),
        .counter1_output(counter1_output),
        .routing_level(routing_level),
        .analog_trigger_sel(analog_trigger_sel),
        .general_io_lines(gio), .counter0_up_down(counter0_up_down),
        .counter1_up_down(counter1_up_down));

    ext_circuit u_ext_circuit (
        .pin_out(pin_out), .pin_oe(pin_oe), .ext_drive(ext),
        .per_conversion_pulse(per_conversion_pulse),
        .pin_level(pin_level), .scan_count(scan_count),
        .input_sel(input_sel));

    always #5 clock = ~clock;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rdata);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        rdata = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus(1'b1, a, d, unused);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask

    task automatic state_is(input logic [2:0] exp);
        logic [31:0] r;
        bus(1'b0, 8'h0c, 32'h0, r);
        chk(r[10:8], exp);
    endtask

    task automatic fire(input int k);
        ev[k] <= 1'b1;
        @(posedge clock);
        ev[k] <= 1'b0;
        repeat (3) @(posedge clock);
    endtask

    task automatic report_and_stop();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clock);
        fails++;
        report_and_stop();
    end

    initial begin
        clock = 1'b0;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        ev = '0;
        ext = 6'h2b;
        gio = 8'h00;
        fails = 0;
        checked = 0;
        repeat (20) @(posedge clock);
        chk(pin_oe, 32'h0);
        chk(pin_out, 32'h3f);
        chk(software_strobe_n, 32'h1);
        rst <= 1'b0;
        @(posedge clock);
        rdchk(8'h00, 32'h0);
        rdchk(8'h04, 32'h0);
        rdchk(8'h08, 32'h1);
        wr(8'h10, 32'hffff_ffff);
        rdchk(8'h10, 32'h0);
        chk(hresp, 32'h0);
        rdchk(8'h0c, 32'h12b);
        chk(routing_level, 32'h2b);
        wr(8'h00, 32'h2);
        repeat (2) @(posedge clock);
        chk(analog_trigger_sel, 32'h1);
        chk(routing_level, 32'h2a);
        wr(8'h00, 32'h0);
        for (int i = 1; i < 4; i++) begin
            gio <= {i[1:0], 6'h15};
            repeat (3) @(posedge clock);
            chk({counter1_up_down, counter0_up_down}, i);
        end
        ev[2:0] <= 3'b011;
        wr(8'h04, 32'h18);
        repeat (2) @(posedge clock);
        chk(pin_level, 32'h33);
        chk(counter1_output, 32'h1);
        ev[2:0] <= 3'b100;
        repeat (3) @(posedge clock);
        chk(pin_level, 32'h2b);
        chk(counter1_output, 32'h0);
        wr(8'h04, 32'h3f);
        fire(EV_CONV);
        chk(pin_level[2], 32'h0);
        fire(EV_UPD);
        chk(pin_level[5], 32'h0);
        repeat (8) @(posedge clock);
        chk(pin_level[5:2], 32'hb);
        fire(EV_SAMP);
        chk(scan_count, 32'h0);
        wr(8'h00, 32'h1);
        repeat (3) begin
            fire(EV_SAMP);
            repeat (5) @(posedge clock);
        end
        chk(scan_count, 32'h3);
        chk(input_sel, 32'h1);
        fire(EV_START);
        chk(pin_out[0], 32'h1);
        state_is(3'b100);
        fire(EV_REF);
        chk(pin_out[1], 32'h0);
        fire(EV_DONE);
        state_is(3'b001);
        wr(8'h00, 32'h5);
        fire(EV_START);
        chk(pin_out[1:0], 32'h1);
        state_is(3'b010);
        fire(EV_REF);
        chk(pin_out[1:0], 32'h2);
        state_is(3'b100);
        fire(EV_DONE);
        state_is(3'b001);
        wr(8'h08, 32'h0);
        chk(software_strobe_n, 32'h0);
        rdchk(8'h08, 32'h0);
        wr(8'h08, 32'h1);
        chk(software_strobe_n, 32'h1);
        report_and_stop();
    end
endmodule
